// file: shared/sdrcd_pkg.sv
`default_nettype none
package sdrcd_pkg;
    // ========================================
    // timebase
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BIT_HZ = 12_000;
    localparam int unsigned BIT_CYC = CLK_HZ / BIT_HZ;
    localparam int unsigned BIT_HALF = BIT_CYC / 2;
    localparam int unsigned CNT_W = 10;
    // filter clock in tenths of a hertz, 341.3 kHz
    localparam int unsigned FILT_HZ_X10 = 3_413_000;
    localparam int unsigned FILT_CYC = (CLK_HZ * 10) / FILT_HZ_X10;
    localparam int unsigned FILT_HIGH = (FILT_CYC + 1) / 2;
    localparam int unsigned FILT_W = 6;
    localparam int unsigned TONE_HZ = 1_000;
    localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam int unsigned TONE_W = 16;
    // ========================================
    // stream and detector
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned UNITS = 8;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned MARK_BITS = 16;
    localparam int unsigned LOSS_BITS = 64;
    localparam int unsigned RUN_W = 8;
    localparam logic [RUN_W-1:0] RUN_MAX = 8'hff;
    // ========================================
    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [TONE_W-1:0] TONE_RST = 16'h0000;
    typedef enum logic {
        SDRCD_SEARCH = 1'b0,
        SDRCD_LOCKED = 1'b1
    } sdrcd_state_t;
endpackage
`default_nettype wire

// file: shared/sdrcd_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdrcd_fifo_if #(parameter int unsigned W = 8);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport fifo (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready,
                  input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// file: rtl/sdrcd_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sdrcd_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic mclk,
    input wire logic arst_n,
    sdrcd_fifo_if.fifo f
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sdrcd_fifo_st_t;

    sdrcd_fifo_st_t st_reg;
    sdrcd_fifo_st_t st_next;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign f.wr_ready = st_reg.cnt != (AW+1)'(DEPTH);
    assign f.rd_valid = st_reg.cnt != '0;
    assign f.rd_data = mem[st_reg.rp];
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_ready && f.rd_valid;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wp = st_reg.wp + AW'(1);
        end
        if (pop) begin
            st_next.rp = st_reg.rp + AW'(1);
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[st_reg.wp] <= f.wr_data;
        end
    end
endmodule
`default_nettype wire

// file: rtl/sdrcd_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdrcd_top #(
    parameter int unsigned TONE_HALF = sdrcd_pkg::TONE_HALF_CYC,
    parameter int unsigned MARK_LEN = sdrcd_pkg::MARK_BITS,
    parameter int unsigned LOSS_LEN = sdrcd_pkg::LOSS_BITS
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic line_data_in,
    input wire logic [sdrcd_pkg::UNITS-1:0] encrypted_unit_output,
    input wire logic encrypt_mode,
    input wire logic full_duplex,
    input wire logic [2:0] key_sel,
    input wire logic proc_code_ok,
    input wire logic tone_sel,
    output logic [sdrcd_pkg::BYTE_W-1:0] rx_byte,
    output logic rx_byte_valid,
    output logic begin_marker_pattern,
    output logic end_marker_pattern,
    output logic transmit_code_found,
    output logic threshold_fast_avg,
    output logic coded_data_out,
    output logic recovered_clk,
    output logic filter_clk,
    output logic buffer_ready,
    output logic buffer_overrun
);
    localparam int unsigned CW = sdrcd_pkg::CNT_W;
    localparam int unsigned RW = sdrcd_pkg::RUN_W;
    localparam int unsigned TW = sdrcd_pkg::TONE_W;
    localparam logic [CW-1:0] LAST = CW'(sdrcd_pkg::BIT_CYC - 1);
    localparam logic [CW-1:0] HALF = CW'(sdrcd_pkg::BIT_HALF);
    localparam logic [RW-1:0] MARK_AT = RW'(MARK_LEN - 1);
    localparam logic [RW-1:0] LOSS_AT = RW'(LOSS_LEN);
    localparam logic [TW-1:0] TONE_AT = TW'(TONE_HALF - 1);
    localparam logic [5:0] FILT_AT = 6'(sdrcd_pkg::FILT_CYC - 1);
    localparam logic [5:0] FILT_HI = 6'(sdrcd_pkg::FILT_HIGH);

    if (MARK_LEN < 2 || MARK_LEN > 255 || LOSS_LEN < 1 || LOSS_LEN > 254
        || TONE_HALF < 1 || TONE_HALF > 65535) begin : g_bad_param
        $error("marker, loss or tone count out of range");
    end

    // ========================================
    // state
    typedef struct packed {
        logic line_s1;
        logic line_s2;
        logic [sdrcd_pkg::UNITS-1:0] ciph_s1;
        logic [sdrcd_pkg::UNITS-1:0] ciph_s2;
        logic src_d;
        logic [CW-1:0] cnt;
        logic [7:0] shreg;
        logic [2:0] bitn;
        logic [7:0] byte_q;
        logic byte_stb;
        logic last_bit;
        logic [RW-1:0] run;
        logic edge_seen;
        logic [RW-1:0] quiet;
        sdrcd_pkg::sdrcd_state_t state;
        logic begin_p;
        logic end_p;
        logic overrun;
        logic [7:0] ser;
        logic [3:0] ser_n;
        logic ser_bit;
        logic coded;
        logic [5:0] fcnt;
        logic fclk;
        logic [TW-1:0] tcnt;
        logic tone;
    } sdrcd_st_t;

    sdrcd_st_t st_reg;
    sdrcd_st_t st_next;
    sdrcd_fifo_if #(.W(sdrcd_pkg::BYTE_W)) fq ();

    logic src;
    logic trans;
    logic hold;
    logic jump;
    logic samp;
    logic tx_tick;
    logic marker;
    logic [2:0] unit;

    // full duplex pairs unit k with k+4, so only the low four encrypt
    function automatic logic [2:0] sdrcd_unit(input logic fdx,
                                              input logic [2:0] sel);
        sdrcd_unit = fdx ? {1'b0, sel[1:0]} : sel;
    endfunction

    // ========================================
    // next state
    always_comb begin
        unit = sdrcd_unit(full_duplex, key_sel);
        src = encrypt_mode ? st_reg.ciph_s2[unit] : st_reg.line_s2;
        trans = src != st_reg.src_d;
        hold = trans && (st_reg.cnt > HALF);
        // a skip from just below the falling edge would miss the drain tick
        jump = trans && (st_reg.cnt < HALF - CW'(1));
        samp = (st_reg.cnt == LAST) && !hold;
        tx_tick = st_reg.cnt == HALF;
        marker = 1'b0;
        st_next = st_reg;
        st_next.line_s1 = line_data_in;
        st_next.line_s2 = st_reg.line_s1;
        st_next.ciph_s1 = encrypted_unit_output;
        st_next.ciph_s2 = st_reg.ciph_s1;
        st_next.src_d = src;
        st_next.byte_stb = 1'b0;
        st_next.begin_p = 1'b0;
        st_next.end_p = 1'b0;
        st_next.overrun = st_reg.byte_stb && !fq.wr_ready;
        // late edge holds the count, early edge skips ahead
        if (hold) begin
            st_next.cnt = st_reg.cnt;
        end else if (samp) begin
            st_next.cnt = '0;
        end else if (jump) begin
            st_next.cnt = st_reg.cnt + CW'(2);
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
        if (trans) begin
            st_next.edge_seen = 1'b1;
        end
        if (samp) begin
            st_next.shreg = {st_reg.shreg[6:0], src};
            st_next.bitn = st_reg.bitn + 3'h1;
            if (st_reg.bitn == 3'h7) begin
                st_next.byte_q = {st_reg.shreg[6:0], src};
                st_next.byte_stb = 1'b1;
            end
            st_next.last_bit = src;
            if (src == st_reg.last_bit) begin
                st_next.run = '0;
            end else if (st_reg.run != sdrcd_pkg::RUN_MAX) begin
                st_next.run = st_reg.run + RW'(1);
            end
            marker = (src != st_reg.last_bit)
                && (st_reg.run == MARK_AT - RW'(1));
            st_next.edge_seen = 1'b0;
            if (st_reg.edge_seen || trans) begin
                st_next.quiet = '0;
            end else if (st_reg.quiet != sdrcd_pkg::RUN_MAX) begin
                st_next.quiet = st_reg.quiet + RW'(1);
            end
        end
        unique case (st_reg.state)
            sdrcd_pkg::SDRCD_SEARCH: begin
                if (marker || proc_code_ok) begin
                    st_next.state = sdrcd_pkg::SDRCD_LOCKED;
                    st_next.begin_p = marker;
                end
            end
            sdrcd_pkg::SDRCD_LOCKED: begin
                st_next.end_p = marker;
                if (!proc_code_ok && !marker && st_reg.quiet >= LOSS_AT) begin
                    st_next.state = sdrcd_pkg::SDRCD_SEARCH;
                end
            end
        endcase
        // serialiser drains at the falling edge, msb first
        if (tx_tick) begin
            if (st_reg.ser_n == 4'h0 && fq.rd_valid) begin
                st_next.ser_bit = fq.rd_data[7];
                st_next.ser = {fq.rd_data[6:0], 1'b0};
                st_next.ser_n = 4'h7;
            end else if (st_reg.ser_n != 4'h0) begin
                st_next.ser_bit = st_reg.ser[7];
                st_next.ser = {st_reg.ser[6:0], 1'b0};
                st_next.ser_n = st_reg.ser_n - 4'h1;
            end else begin
                st_next.ser_bit = 1'b0;
            end
        end
        if (tone_sel) begin
            st_next.coded = st_reg.tone;
        end else if (st_reg.state == sdrcd_pkg::SDRCD_LOCKED) begin
            st_next.coded = st_reg.ser_bit;
        end else begin
            st_next.coded = 1'b0;
        end
        st_next.fcnt = (st_reg.fcnt == FILT_AT) ? 6'h00 : st_reg.fcnt + 6'h01;
        st_next.fclk = st_next.fcnt < FILT_HI;
        if (st_reg.tcnt == TONE_AT) begin
            st_next.tcnt = '0;
            st_next.tone = ~st_reg.tone;
        end else begin
            st_next.tcnt = st_reg.tcnt + TW'(1);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.cnt <= sdrcd_pkg::CNT_RST;
            st_reg.tcnt <= sdrcd_pkg::TONE_RST;
            st_reg.state <= sdrcd_pkg::SDRCD_SEARCH;
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // buffer
    assign fq.wr_valid = st_reg.byte_stb;
    assign fq.wr_data = st_reg.byte_q;
    assign fq.rd_ready = tx_tick && (st_reg.ser_n == 4'h0);

    sdrcd_fifo #(.W(sdrcd_pkg::BYTE_W), .DEPTH(sdrcd_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .f(fq)
    );

    // ========================================
    // outputs
    assign rx_byte = st_reg.byte_q;
    assign rx_byte_valid = st_reg.byte_stb;
    assign begin_marker_pattern = st_reg.begin_p;
    assign end_marker_pattern = st_reg.end_p;
    assign transmit_code_found = st_reg.state == sdrcd_pkg::SDRCD_LOCKED;
    assign threshold_fast_avg = st_reg.state == sdrcd_pkg::SDRCD_SEARCH;
    assign coded_data_out = st_reg.coded;
    assign recovered_clk = st_reg.cnt < HALF;
    assign filter_clk = st_reg.fclk;
    assign buffer_ready = fq.wr_ready;
    assign buffer_overrun = st_reg.overrun;

    // ========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_late_edge;
        trans && (st_reg.cnt > HALF);
    endsequence
    property p_phase_hold;
        s_late_edge |=> st_reg.cnt == $past(st_reg.cnt);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("late edge did not slip the bit clock");

    property p_byte_pack;
        (samp && st_reg.bitn == 3'h7)
            |=> rx_byte_valid && rx_byte == $past({st_reg.shreg[6:0], src});
    endproperty
    a_byte_pack: assert property (p_byte_pack) else $error("byte not packed on eighth bit");

    property p_marker_found;
        (samp && marker && threshold_fast_avg) |=> begin_marker_pattern;
    endproperty
    a_marker_found: assert property (p_marker_found) else $error("alternating run not reported");

    sequence s_begin;
        begin_marker_pattern;
    endsequence
    property p_code_lit;
        s_begin |-> transmit_code_found ##1 transmit_code_found;
    endproperty
    a_code_lit: assert property (p_code_lit) else $error("code found not lit on marker");

    property p_gate;
        (!transmit_code_found && !tone_sel) |=> !coded_data_out;
    endproperty
    a_gate: assert property (p_gate) else $error("data left before code found");

    property p_thresh;
        $fell(transmit_code_found) |-> threshold_fast_avg ##1 !end_marker_pattern;
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold gate not back to search");

    property p_filt;
        $rose(filter_clk) |=> (!$rose(filter_clk)) [*8];
    endproperty
    a_filt: assert property (p_filt) else $error("filter clock too fast");

    property p_tone;
        $changed(st_reg.tone) |-> $past(st_reg.tcnt) == TONE_AT;
    endproperty
    a_tone: assert property (p_tone) else $error("tone half period wrong");

    property p_pair;
        (encrypt_mode && full_duplex) |-> !unit[2] && unit[1:0] == key_sel[1:0];
    endproperty
    a_pair: assert property (p_pair) else $error("full duplex picked an upper unit");
endmodule
`default_nettype wire

// file: dv/sdrcd_line_src.sv
`timescale 1ns/1ps
`default_nettype none
module sdrcd_line_src #(
    parameter int BIT_LEN = 833
) (
    input wire logic mclk,
    output var logic line
);
    // ========================================
    // wireline sender, one bit per bit period, first bit first
    initial line = 1'h0;
    // entered just after a rising edge, returns the same way
    task automatic send(input logic [7:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            line = bits[i];
            repeat (BIT_LEN) @(posedge mclk);
            #1;
        end
        // released line rests at the inverse of the last bit
        line = ~bits[0];
    endtask
endmodule
`default_nettype wire

// file: dv/sdrcd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdrcd_top_tb;
    localparam int TH = 10;
    localparam int LL = 4;
    localparam int BC = sdrcd_pkg::BIT_CYC;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic line_data_in;
    logic [7:0] units = 8'h00;
    logic encrypt_mode = 1'h0;
    logic full_duplex = 1'h0;
    logic [2:0] key_sel = 3'h0;
    logic proc_code_ok = 1'h0;
    logic tone_sel = 1'h0;
    logic [7:0] rx_byte;
    logic rx_byte_valid, begin_marker_pattern, end_marker_pattern;
    logic transmit_code_found, threshold_fast_avg, coded_data_out;
    logic recovered_clk, filter_clk, buffer_ready, buffer_overrun;
    int failures = 0;
    int samples_checked = 0;
    int overruns = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) if (buffer_overrun === 1'h1) overruns++;
    sdrcd_top #(.TONE_HALF(TH), .MARK_LEN(4), .LOSS_LEN(LL)) u_sdrcd_top (
        .mclk(mclk), .arst_n(arst_n), .line_data_in(line_data_in),
        .encrypted_unit_output(units), .encrypt_mode(encrypt_mode),
        .full_duplex(full_duplex), .key_sel(key_sel),
        .proc_code_ok(proc_code_ok), .tone_sel(tone_sel),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
        .begin_marker_pattern(begin_marker_pattern),
        .end_marker_pattern(end_marker_pattern),
        .transmit_code_found(transmit_code_found),
        .threshold_fast_avg(threshold_fast_avg),
        .coded_data_out(coded_data_out), .recovered_clk(recovered_clk),
        .filter_clk(filter_clk), .buffer_ready(buffer_ready),
        .buffer_overrun(buffer_overrun));
    sdrcd_line_src #(.BIT_LEN(BC)) u_sdrcd_line_src (
        .mclk(mclk), .line(line_data_in));
    // ========================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic fail(input string msg);
        failures++;
        $display("CHECK FAILED %0t %s", $time, msg);
    endtask
    task automatic check_bit(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              input string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask
    task automatic check_cnt(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp) fail(m);
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? filter_clk : w == 1 ? recovered_clk : coded_data_out;
    endfunction
    // cycles until the watched signal changes level
    task automatic run_len(input int w, input int lim, output int n);
        logic v;
        v = sig(w);
        n = 0;
        while (sig(w) === v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic wait_valid;
        step(1);
        for (int i = 0; i < 8 * BC + 50 && rx_byte_valid !== 1'h1; i++)
            step(1);
        check_bit(rx_byte_valid, 1'h1, "no byte");
    endtask
    task automatic check_rst;
        check_bit(transmit_code_found, 1'h0, "found after reset");
        check_bit(threshold_fast_avg, 1'h1, "gate after reset");
        check_bit(coded_data_out, 1'h0, "out after reset");
        check_bit(recovered_clk, 1'h1, "clk after reset");
    endtask
    // ========================================
    // scenarios
    task automatic t_clocks;
        int n, a, b;
        run_len(0, 40, n);
        run_len(0, 40, a);
        run_len(0, 40, b);
        check_cnt(a + b, 29, "filter period");
        check_cnt(a > b ? a : b, 15, "filter high");
        run_len(1, 900, n);
        run_len(1, 900, a);
        run_len(1, 900, b);
        check_cnt(a + b, BC, "bit clock period");
        check_cnt(a < b ? a : b, BC / 2, "bit clock high");
    endtask
    task automatic t_pack;
        wait_valid();
        step(BC / 2 - 1);
        fork
            u_sdrcd_line_src.send(8'hc3, 8);
            begin
                wait_valid();
                // switch source on the byte boundary for the next scenario
                encrypt_mode = 1'h1;
                units = 8'h96;
            end
        join
        check_byte(rx_byte, 8'hc3, "packed byte");
        check_bit(transmit_code_found, 1'h0, "no code yet");
        check_bit(coded_data_out, 1'h0, "gated out");
        check_bit(threshold_fast_avg, 1'h1, "gate searching");
    endtask
    task automatic t_mux;
        for (int k = 0; k < 9; k++) begin
            key_sel = (k < 8) ? k[2:0] : 3'h6;
            full_duplex = (k == 8);
            wait_valid();
            check_byte(rx_byte, {8{units[k < 8 ? k : 2]}}, "unit");
        end
        check_byte(rx_byte, 8'hff, "duplex pair");
        step(1);
        check_bit(rx_byte_valid, 1'h0, "valid pulse");
    endtask
    task automatic t_marker;
        int nb, ne, bad, ones;
        nb = 0;
        ne = 0;
        bad = 0;
        ones = 0;
        encrypt_mode = 1'h0;
        full_duplex = 1'h0;
        step(BC / 2 - 1);
        fork
            u_sdrcd_line_src.send(8'ha5, 8);
            for (int i = 0; i < (11 + LL) * BC; i++) begin
                step(1);
                nb += (begin_marker_pattern === 1'h1);
                ne += (end_marker_pattern === 1'h1);
                ones += (transmit_code_found === 1'h1 && coded_data_out);
                bad += (threshold_fast_avg !== ~transmit_code_found);
                bad += (transmit_code_found !== 1'h1 && coded_data_out);
                bad += (begin_marker_pattern && !transmit_code_found);
            end
        join
        check_cnt(nb, 1, "begin pulse");
        check_cnt(ne, 1, "end pulse");
        check_cnt(bad, 0, "found, gate and gating");
        check_bit(ones > 0, 1'h1, "forwarded data");
        check_bit(transmit_code_found, 1'h0, "lost code");
        check_bit(threshold_fast_avg, 1'h1, "gate back");
    endtask
    task automatic t_tone;
        int n, a, b;
        tone_sel = 1'h1;
        run_len(2, 40, n);
        run_len(2, 40, a);
        run_len(2, 40, b);
        check_cnt(a, TH, "tone half");
        check_cnt(b, TH, "tone half");
        tone_sel = 1'h0;
        step(3);
        check_bit(coded_data_out, 1'h0, "tone off");
    endtask
    task automatic t_proc;
        proc_code_ok = 1'h1;
        step(3);
        check_bit(transmit_code_found, 1'h1, "processor lock");
        check_bit(threshold_fast_avg, 1'h0, "gate locked");
        proc_code_ok = 1'h0;
        for (int i = 0; i < (LL + 3) * BC && transmit_code_found; i++)
            step(1);
        check_bit(transmit_code_found, 1'h0, "quiet unlock");
        proc_code_ok = 1'h1;
        step(3);
        arst_n = 1'h0;
        proc_code_ok = 1'h0;
        #10;
        check_rst();
        step(3);
        arst_n = 1'h1;
        step(1);
        check_rst();
    endtask
    // ========================================
    // sequence and watchdog
    initial begin
        step(4);
        arst_n = 1'h1;
        step(1);
        check_rst();
        t_clocks();
        t_pack();
        t_mux();
        t_marker();
        t_tone();
        t_proc();
        check_bit(buffer_ready, 1'h1, "buffer ready");
        check_cnt(overruns, 0, "overrun");
        test_done();
    end
    initial begin
        repeat (98000) @(posedge mclk);
        fail("watchdog");
        test_done();
    end
endmodule
`default_nettype wire
